// ===== bench/tb_top.sv
// self-checking bench for the logic and bit operations datapath
// assumes lbo_pkg and lbo_cfg.svh are compiled ahead of it
`timescale 1ns/1ns
module tb_top;
   // ****************
   // stimulus
   // ****************
   logic clock = 1'h0;
   logic rst_n = 1'h0;
   lbo_pkg::lbo_op_type opcode = lbo_pkg::LBO_OP_NONE;
   logic [6:0] fileAddr = 7'h00;
   logic [2:0] bitSelect = 3'h0;
   logic resultTargetSelect = 1'h0;
   logic [7:0] literal = 8'h00;
   logic [7:0] fileReadData = 8'h00;
   logic fileWriteEnable;
   logic [6:0] fileWriteAddr;
   logic [7:0] fileWriteData;
   logic [7:0] workingRegister;
   logic resultNullFlag;
   int badCount = 0;
   int testsRun = 0;

   always #4 clock = ~clock;

   logic_and_bit_ops u_dut (.clock(clock), .rst_n(rst_n), .opcode(opcode), .fileAddr(fileAddr),
      .bitSelect(bitSelect), .resultTargetSelect(resultTargetSelect), .literal(literal),
      .fileReadData(fileReadData), .fileWriteEnable(fileWriteEnable), .fileWriteAddr(fileWriteAddr),
      .fileWriteData(fileWriteData), .workingRegister(workingRegister), .resultNullFlag(resultNullFlag));

   // ****************
   // helpers
   // ****************
   task automatic endSim();
      if (badCount == 0 && testsRun > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic check(input logic [7:0] seen, input logic [7:0] want, input string what);
      testsRun++;
      if (seen !== want) begin
         $display("ERROR %0t %s", $time, what);
         badCount++;
      end
   endtask

   // drives one op just after an edge, returns just after the executing edge
   task automatic runOp(input lbo_pkg::lbo_op_type op, input logic [6:0] a, input logic [2:0] b,
                        input logic d, input logic [7:0] lit, input logic [7:0] rd);
      opcode = op;
      fileAddr = a;
      bitSelect = b;
      resultTargetSelect = d;
      literal = lit;
      fileReadData = rd;
      @(posedge clock);
      #1;
   endtask

   // ****************
   // scenarios
   // ****************
   task automatic testBits();
      for (int i = 0; i < 8; i++) begin
         runOp(lbo_pkg::LBO_OP_CLR_BIT, 7'(i * 16 + 5), 3'(i), 1'h1, 8'h00, 8'hFF);
         check(fileWriteData, 8'hFF & ~(8'h01 << i), "clear data");
         check({1'h0, fileWriteAddr}, 8'(i * 16 + 5), "clear addr");
         check({fileWriteEnable, resultNullFlag, workingRegister[5:0]}, 8'h80, "clear side");
         runOp(lbo_pkg::LBO_OP_SET_BIT, 7'h7F, 3'(i), 1'h0, 8'hFF, 8'h00);
         check(fileWriteData, 8'h01 << i, "set data");
         check({fileWriteEnable, resultNullFlag, fileWriteAddr[5:0]}, 8'hBF, "set side");
      end
   endtask

   task automatic testAnd();
      runOp(lbo_pkg::LBO_OP_LOAD_WORK, 7'h00, 3'h0, 1'h0, 8'h5A, 8'h00);
      check(workingRegister, 8'h5A, "load working");
      runOp(lbo_pkg::LBO_OP_AND_FILE, 7'h7F, 3'h0, 1'h1, 8'hFF, 8'hAF);
      check({fileWriteEnable, resultNullFlag, fileWriteAddr[5:0]}, 8'hBF, "and file wb");
      check(fileWriteData, 8'h0A, "and file data");
      check(workingRegister, 8'h5A, "and file work kept");
      runOp(lbo_pkg::LBO_OP_AND_FILE, 7'h00, 3'h0, 1'h0, 8'hFF, 8'h3C);
      check({fileWriteEnable, resultNullFlag, 6'h00}, 8'h00, "and file work");
      check(workingRegister, 8'h18, "and file result");
      runOp(lbo_pkg::LBO_OP_AND_LIT, 7'h11, 3'h0, 1'h1, 8'hE7, 8'hFF);
      check({fileWriteEnable, resultNullFlag, 6'h00}, 8'h40, "and lit flag");
      check(workingRegister, 8'h00, "and lit result");
      runOp(lbo_pkg::LBO_OP_LOAD_WORK, 7'h00, 3'h0, 1'h0, 8'h5A, 8'h00);
      runOp(lbo_pkg::LBO_OP_AND_LIT, 7'h00, 3'h0, 1'h0, 8'hAF, 8'h00);
      check({fileWriteEnable, resultNullFlag, workingRegister[5:0]}, 8'h0A, "and lit flag clear");
      check(workingRegister, 8'h0A, "and lit nonzero");
      runOp(lbo_pkg::LBO_OP_AND_FILE, 7'h2A, 3'h0, 1'h1, 8'h00, 8'hF5);
      check({fileWriteEnable, resultNullFlag, fileWriteAddr[5:0]}, 8'hEA, "and file zero");
      check(fileWriteData, 8'h00, "and file zero data");
   endtask

   task automatic testIdle();
      runOp(lbo_pkg::lbo_op_type'(3'h7), 7'h22, 3'h1, 1'h1, 8'h00, 8'h33);
      check({fileWriteEnable, resultNullFlag, fileWriteAddr[5:0]}, 8'h6A, "unknown op");
      check(fileWriteData, 8'h00, "write data held");
      check(workingRegister, 8'h0A, "unknown op work");
      runOp(lbo_pkg::LBO_OP_NONE, 7'h33, 3'h2, 1'h1, 8'hFF, 8'hFF);
      check({fileWriteEnable, resultNullFlag, workingRegister[5:0]}, 8'h4A, "no op");
   endtask

   task automatic testHold();
      runOp(lbo_pkg::LBO_OP_CLR_BIT, 7'h40, 3'h3, 1'h0, 8'h00, 8'h5A);
      check(fileWriteData, 8'h52, "clear keeps others");
      check({fileWriteEnable, resultNullFlag, workingRegister[5:0]}, 8'hCA, "clear flags held");
      runOp(lbo_pkg::LBO_OP_SET_BIT, 7'h41, 3'h2, 1'h0, 8'h00, 8'h5A);
      check(fileWriteData, 8'h5E, "set keeps others");
      check({fileWriteEnable, resultNullFlag, fileWriteAddr[5:0]}, 8'hC1, "set flags held");
      check(workingRegister, 8'h0A, "set work held");
   endtask

   // mid-run reset: outputs clear at once, ops run again from the first edge after release
   task automatic testReset();
      rst_n = 1'h0;
      #1;
      check({fileWriteEnable, resultNullFlag, fileWriteAddr[5:0]}, 8'h00, "reset flags");
      check(workingRegister, 8'h00, "reset work");
      check(fileWriteData, 8'h00, "reset data");
      repeat (3) @(posedge clock);
      #1;
      rst_n = 1'h1;
      runOp(lbo_pkg::LBO_OP_LOAD_WORK, 7'h00, 3'h0, 1'h0, 8'hC3, 8'h00);
      runOp(lbo_pkg::LBO_OP_AND_LIT, 7'h00, 3'h0, 1'h0, 8'h81, 8'h00);
      check(workingRegister, 8'h81, "and after reset");
   endtask

   // ****************
   // main sequence
   // ****************
   initial begin
      #100000;
      badCount++;
      endSim();
   end

   initial begin
      repeat (20) @(posedge clock);
      #1;
      rst_n = 1'h1;
      check({fileWriteEnable, resultNullFlag, 6'h00}, 8'h00, "reset outputs");
      check(workingRegister, 8'h00, "reset working");
      testBits();
      testAnd();
      testIdle();
      testHold();
      testReset();
      endSim();
   end
endmodule

// ===== include/lbo_cfg.svh
// constants for the logic and bit operations datapath
// assumes inclusion by bare name from the package and design files
`ifndef LBO_CFG_SVH
`define LBO_CFG_SVH
`define LBO_DATA_W 8
`define LBO_ADDR_W 7
`define LBO_ADDR_MAX 7'h7F
`define LBO_BIT_W 3
`define LBO_DEST_WORK 1'h0
`define LBO_DEST_FILE 1'h1
`define LBO_WORK_RESET 8'h00
`define LBO_NULL_RESET 1'h0
`define LBO_OP_CYCLES 1
`endif

// ===== include/lbo_pkg.sv
// types for the logic and bit operations datapath
// assumes lbo_cfg.svh is on the include path
`include "lbo_cfg.svh"
package lbo_pkg;
   typedef enum logic [2:0] {
      LBO_OP_NONE = 3'h0,
      LBO_OP_AND_FILE = 3'h1,
      LBO_OP_AND_LIT = 3'h2,
      LBO_OP_CLR_BIT = 3'h3,
      LBO_OP_SET_BIT = 3'h4,
      // working register written from literal, standing in for the rest of the core
      LBO_OP_LOAD_WORK = 3'h5
   } lbo_op_type;
endpackage

// ===== rtl/lbo_bit_mask.sv
// one-hot mask generator for a bit position
// assumes bit position is in range of the data width
`timescale 1ns/1ns
`include "lbo_cfg.svh"
module lbo_bit_mask #(
   parameter int DATA_W = `LBO_DATA_W,
   parameter int BIT_W = `LBO_BIT_W
) (
   // position in
   input wire logic [BIT_W-1:0] bitPos,
   // one-hot mask out
   output logic [DATA_W-1:0] mask
);
   if ((1 << BIT_W) != DATA_W) begin
      $error("bit position width does not match data width");
   end

   always_comb begin
      mask = '0;
      mask[bitPos] = 1'h1;
   end
endmodule

// ===== rtl/logic_and_bit_ops.sv
// datapath for the AND and single-bit clear/set instructions
// assumes decode presents one operation per cycle with its file operand already read
`timescale 1ns/1ns
`include "lbo_cfg.svh"

// Functional notes
// - and_working_with_file ANDs working_register with file register 0..127, only zero flag, one cycle.
// - destination select 0 writes working_register, 1 writes back the addressed file register.
// - and_working_with_literal ANDs working_register with 8-bit literal into working_register, one cycle.
// - clear_file_bit forces chosen bit 0..7 of file register to zero, no flag change.
// - set_file_bit forces chosen bit 0..7 of file register to one, no flag change.
module logic_and_bit_ops #(
   parameter int DATA_W = `LBO_DATA_W,
   parameter int ADDR_W = `LBO_ADDR_W,
   parameter int BIT_W = `LBO_BIT_W
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // decoded instruction
   input wire lbo_pkg::lbo_op_type opcode,
   input wire logic [ADDR_W-1:0] fileAddr,
   input wire logic [BIT_W-1:0] bitSelect,
   input wire logic resultTargetSelect,
   input wire logic [DATA_W-1:0] literal,
   // file register read data for fileAddr
   input wire logic [DATA_W-1:0] fileReadData,
   // file register write back
   output logic fileWriteEnable,
   output logic [ADDR_W-1:0] fileWriteAddr,
   output logic [DATA_W-1:0] fileWriteData,
   // core state
   output logic [DATA_W-1:0] workingRegister,
   output logic resultNullFlag
);
   // ****************************************
   // parameter checks
   // ****************************************
   // flag, mask and check logic assume a byte wide datapath
   if (DATA_W != `LBO_DATA_W) begin
      $error("datapath width must be one byte");
   end
   // file addresses beyond seven bits have no meaning for this core
   if (ADDR_W < 1 || ADDR_W > `LBO_ADDR_W) begin
      $error("unsupported file address width");
   end
   // every bit select value must name a bit of the byte
   if ((1 << BIT_W) != DATA_W) begin
      $error("bit select width does not match data width");
   end

   // ****************************************
   // state
   // ****************************************
   // outputs are driven straight from this register
   typedef struct packed {
      logic [DATA_W-1:0] work;
      logic nullFlag;
      logic wrEn;
      logic [ADDR_W-1:0] wrAddr;
      logic [DATA_W-1:0] wrData;
   } lbo_state_type;

   lbo_state_type state;
   lbo_state_type next_state;
   logic [DATA_W-1:0] bitMask;
   logic [DATA_W-1:0] andResult;

   lbo_bit_mask #(
      .DATA_W(DATA_W),
      .BIT_W(BIT_W)
   ) u_mask (
      .bitPos(bitSelect),
      .mask(bitMask)
   );

   // ****************************************
   // helpers
   // ****************************************
   function automatic logic isZero(input logic [DATA_W-1:0] value);
      return value == '0;
   endfunction

   // true for the two operations that own the zero flag
   function automatic logic isAndOp(input lbo_pkg::lbo_op_type op);
      return op == lbo_pkg::LBO_OP_AND_FILE || op == lbo_pkg::LBO_OP_AND_LIT;
   endfunction

   // true for every operation that writes a file register
   function automatic logic isWriteOp(input lbo_pkg::lbo_op_type op, input logic target);
      return op == lbo_pkg::LBO_OP_CLR_BIT || op == lbo_pkg::LBO_OP_SET_BIT
         || (op == lbo_pkg::LBO_OP_AND_FILE && target == `LBO_DEST_FILE);
   endfunction

   // one bit forced to the given level, the rest of the byte kept
   function automatic logic [DATA_W-1:0] bitUpdate(input logic [DATA_W-1:0] value, input logic [DATA_W-1:0] onehot,
                                                   input logic level);
      return level ? (value | onehot) : (value & ~onehot);
   endfunction

   // ****************************************
   // next state
   // ****************************************
   // results land in the registered copy, so each op shows one edge after it is taken
   always_comb begin
      next_state = state;
      // the write strobe is a one cycle pulse per write back op
      next_state.wrEn = 1'h0;
      andResult = '0;
      case (opcode)
         lbo_pkg::LBO_OP_AND_FILE: begin
            andResult = state.work & fileReadData;
            next_state.nullFlag = isZero(andResult);
            if (resultTargetSelect == `LBO_DEST_FILE) begin
               next_state.wrEn = 1'h1;
               next_state.wrAddr = fileAddr;
               next_state.wrData = andResult;
            end else begin
               next_state.work = andResult;
            end
         end
         lbo_pkg::LBO_OP_AND_LIT: begin
            andResult = state.work & literal;
            next_state.work = andResult;
            next_state.nullFlag = isZero(andResult);
         end
         lbo_pkg::LBO_OP_CLR_BIT: begin
            next_state.wrEn = 1'h1;
            next_state.wrAddr = fileAddr;
            next_state.wrData = bitUpdate(fileReadData, bitMask, 1'h0);
         end
         lbo_pkg::LBO_OP_SET_BIT: begin
            next_state.wrEn = 1'h1;
            next_state.wrAddr = fileAddr;
            next_state.wrData = bitUpdate(fileReadData, bitMask, 1'h1);
         end
         lbo_pkg::LBO_OP_LOAD_WORK: begin
            // flag left alone, only the and forms own it
            next_state.work = literal;
         end
         default: begin
            next_state.wrEn = 1'h0;
         end
      endcase
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state.work <= `LBO_WORK_RESET;
         state.nullFlag <= `LBO_NULL_RESET;
         state.wrEn <= 1'h0;
         state.wrAddr <= '0;
         state.wrData <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign workingRegister = state.work;
   assign resultNullFlag = state.nullFlag;
   assign fileWriteEnable = state.wrEn;
   assign fileWriteAddr = state.wrAddr;
   assign fileWriteData = state.wrData;

   // ****************************************
   // instruction checks
   // ****************************************
   // each check looks one edge after the op is taken
   a_and_file_work: assert property (@(posedge clock) disable iff (!rst_n)
      (opcode == lbo_pkg::LBO_OP_AND_FILE && !resultTargetSelect) |=>
      workingRegister == ($past(workingRegister) & $past(fileReadData)) && !fileWriteEnable)
      else $error("and with file to working register wrong");
   a_and_file_back: assert property (@(posedge clock) disable iff (!rst_n)
      (opcode == lbo_pkg::LBO_OP_AND_FILE && resultTargetSelect) |=>
      fileWriteEnable && fileWriteData == ($past(workingRegister) & $past(fileReadData))
      && fileWriteAddr == $past(fileAddr) && $stable(workingRegister))
      else $error("and with file write back wrong");
   a_and_literal: assert property (@(posedge clock) disable iff (!rst_n)
      opcode == lbo_pkg::LBO_OP_AND_LIT |=>
      workingRegister == ($past(workingRegister) & $past(literal)) && !fileWriteEnable)
      else $error("and with literal wrong");
   a_clear_bit: assert property (@(posedge clock) disable iff (!rst_n)
      opcode == lbo_pkg::LBO_OP_CLR_BIT |=>
      fileWriteEnable && fileWriteData[$past(bitSelect)] == 1'b0
      && (fileWriteData | (8'h01 << $past(bitSelect))) == ($past(fileReadData) | (8'h01 << $past(bitSelect)))
      && $stable(resultNullFlag) && $stable(workingRegister))
      else $error("clear bit wrong");
   a_set_bit: assert property (@(posedge clock) disable iff (!rst_n)
      opcode == lbo_pkg::LBO_OP_SET_BIT |=>
      fileWriteEnable && fileWriteData == ($past(fileReadData) | (8'h01 << $past(bitSelect)))
      && $stable(resultNullFlag) && $stable(workingRegister))
      else $error("set bit wrong");
   a_zero_flag: assert property (@(posedge clock) disable iff (!rst_n)
      isAndOp(opcode) |=>
      resultNullFlag == (($past(workingRegister) & ($past(opcode) == lbo_pkg::LBO_OP_AND_LIT ?
      $past(literal) : $past(fileReadData))) == 8'h00))
      else $error("zero flag wrong");
   a_idle_quiet: assert property (@(posedge clock) disable iff (!rst_n)
      opcode == lbo_pkg::LBO_OP_NONE |=> !fileWriteEnable && $stable(workingRegister) && $stable(resultNullFlag))
      else $error("idle cycle changed state");
   a_write_pulse: assert property (@(posedge clock) disable iff (!rst_n)
      !isWriteOp(opcode, resultTargetSelect) |=> !fileWriteEnable)
      else $error("spurious file write");
   a_load_work: assert property (@(posedge clock) disable iff (!rst_n)
      opcode == lbo_pkg::LBO_OP_LOAD_WORK |=>
      workingRegister == $past(literal) && $stable(resultNullFlag) && !fileWriteEnable)
      else $error("working register load wrong");
   a_unknown_quiet: assert property (@(posedge clock) disable iff (!rst_n)
      !(opcode inside {lbo_pkg::LBO_OP_NONE, lbo_pkg::LBO_OP_AND_FILE, lbo_pkg::LBO_OP_AND_LIT,
      lbo_pkg::LBO_OP_CLR_BIT, lbo_pkg::LBO_OP_SET_BIT, lbo_pkg::LBO_OP_LOAD_WORK}) |=>
      !fileWriteEnable && $stable(workingRegister) && $stable(resultNullFlag))
      else $error("unknown opcode changed state");

   // ****************************************
   // hold checks
   // ****************************************
   // a stale write address or data would corrupt the next write back on the file side
   a_write_strobe: assert property (@(posedge clock) disable iff (!rst_n)
      isWriteOp(opcode, resultTargetSelect) |=> fileWriteEnable && fileWriteAddr == $past(fileAddr))
      else $error("file write strobe or address wrong");
   a_write_hold: assert property (@(posedge clock) disable iff (!rst_n)
      !isWriteOp(opcode, resultTargetSelect) |=> $stable(fileWriteAddr) && $stable(fileWriteData))
      else $error("write address or data moved");
   // only the two and forms own the zero flag
   a_flag_only_and: assert property (@(posedge clock) disable iff (!rst_n)
      !isAndOp(opcode) |=> $stable(resultNullFlag))
      else $error("zero flag moved outside an and");
endmodule
